// ---- touch_irq_defines.svh ----
// Purpose: constants of the touch interrupt output configuration block
// Assumes: 250 MHz system clock, 2 MHz internal oscillator
// Notes: register addresses are 7-bit
`ifndef TOUCH_IRQ_DEFINES_SVH
`define TOUCH_IRQ_DEFINES_SVH

`define GEN_STATUS_ADDR 7'h00
`define GEN_CONFIG_ADDR 7'h01
`define GEN_CONFIG_RESET 8'hf0

`define CFG_RSEL_BIT 7
`define CFG_HOLD_BIT 6
`define CFG_PU_BIT 5
`define CFG_OD_BIT 4
`define CFG_MASK_BIT 3
`define CFG_EDGE_BIT 2
`define CFG_ETIME_HI 1
`define CFG_ETIME_LO 0

`define ETIME_CODE_4 2'h0
`define ETIME_CODE_16 2'h1
`define ETIME_CODE_64 2'h2
`define ETIME_TICKS_4 8'h04
`define ETIME_TICKS_16 8'h10
`define ETIME_TICKS_64 8'h40
`define ETIME_TICKS_128 8'h80

`define CLK_PERIOD_NS 4
`define OSC_PERIOD_NS 500

`endif

// ---- touch_irq_pkg.sv ----
// Purpose: shared types of the touch interrupt output configuration block
// Assumes: nothing
// Notes: edge pulse sequencer states
package touch_irq_pkg;
   typedef enum logic {ev_idle, ev_pulse} edge_state_type;
endpackage

// ---- touch_irq_output_config.sv ----
// Purpose: general configuration register and touch interrupt pin driver
// Assumes: register writes and touch inputs are synchronous to clk_sys
// Notes: interrupt pin is active low; open-drain uses output enable only
// Contract
// (R1) edge pulse lasts 4/16/64/128 oscillator periods
// (R2) style 0: pin follows touch or conversion continuously
// (R3) style 1: each touch event gives one pulse; the code ignores touch events that arrive while a pulse is running
// (R4) mask forces pin inactive, high or released
// (R5) drive type selects push-pull or open-drain
// (R6) holder bit enables serial data bus holder
// (R7) edge flag only in direct, edge style
// (R8) continuous flag shows touch or conversion
`timescale 1ns/10ps
`include "touch_irq_defines.svh"

module touch_irq_output_config
   import touch_irq_pkg::*;
#(
   parameter int unsigned OSC_DIV = (`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic reg_wr_en,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic auto_mode,
   input wire logic touch_present,
   input wire logic conv_busy,
   input wire logic touch_event,
   output logic [7:0] reg_rd_data,
   output logic touch_interrupt_pin_o,
   output logic touch_interrupt_pin_oe,
   output logic interrupt_pin_pullup_enable,
   output logic data_out_holder_enable,
   output logic touch_detect_resistor_select,
   output logic edge_event_flag,
   output logic continuous_touch_flag
);

   localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

   if (OSC_DIV < 1 || OSC_DIV > 65536) begin : g_div_check
      $error("OSC_DIV out of range");
   end

   function automatic logic [7:0] edge_ticks(input logic [1:0] code);
      unique case (code)
         `ETIME_CODE_4: edge_ticks = `ETIME_TICKS_4;
         `ETIME_CODE_16: edge_ticks = `ETIME_TICKS_16;
         `ETIME_CODE_64: edge_ticks = `ETIME_TICKS_64;
         default: edge_ticks = `ETIME_TICKS_128;
      endcase
   endfunction

   logic [7:0] cfg_q, cfg_d;
   edge_state_type state_q, state_d;
   logic [15:0] div_q, div_d;
   logic [7:0] left_q, left_d;
   logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
   logic pu_q, pu_d, hold_q, hold_d, rsel_q, rsel_d;
   logic eflag_q, eflag_d, cflag_q, cflag_d;
   logic [7:0] rd_q, rd_d;
   logic edge_style, irq_assert, open_drain;

   // configuration register
   always_comb begin
      cfg_d = cfg_q;
      if (reg_wr_en && reg_addr == `GEN_CONFIG_ADDR) begin
         cfg_d = reg_wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= `GEN_CONFIG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   assign edge_style = !auto_mode && cfg_q[`CFG_EDGE_BIT];
   assign open_drain = cfg_q[`CFG_OD_BIT];

   // edge pulse sequencer, timed in oscillator periods
   always_comb begin
      state_d = state_q;
      div_d = div_q;
      left_d = left_q;
      unique case (state_q)
         ev_idle: begin
            if (edge_style && touch_event) begin // R3
               state_d = ev_pulse;
               div_d = 16'h0000;
               left_d = edge_ticks(cfg_q[`CFG_ETIME_HI:`CFG_ETIME_LO]); // R1
            end
         end
         ev_pulse: begin
            if (div_q == DIV_LAST) begin
               div_d = 16'h0000;
               if (left_q == 8'h01) begin
                  state_d = ev_idle; // R1
               end else begin
                  left_d = left_q - 8'h01;
               end
            end else begin
               div_d = div_q + 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= ev_idle;
         div_q <= 16'h0000;
         left_q <= 8'h00;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         left_q <= left_d;
      end
   end

   // pin drive, flags and read-back
   always_comb begin
      if (cfg_q[`CFG_EDGE_BIT]) begin
         irq_assert = state_q == ev_pulse; // R3
      end else begin
         irq_assert = touch_present || conv_busy; // R2
      end
      if (auto_mode || cfg_q[`CFG_MASK_BIT]) begin
         irq_assert = 1'b0; // R4
      end
      pin_o_d = open_drain ? 1'b0 : !irq_assert; // R5
      pin_oe_d = open_drain ? irq_assert : 1'b1; // R5
      pu_d = cfg_q[`CFG_PU_BIT] && open_drain; // R5
      hold_d = cfg_q[`CFG_HOLD_BIT]; // R6
      rsel_d = cfg_q[`CFG_RSEL_BIT];
      eflag_d = edge_style && touch_present; // R7
      cflag_d = !auto_mode && !cfg_q[`CFG_EDGE_BIT] && (touch_present || conv_busy); // R8
      if (reg_addr == `GEN_STATUS_ADDR) begin
         rd_d = {6'h00, eflag_q, cflag_q};
      end else if (reg_addr == `GEN_CONFIG_ADDR) begin
         rd_d = cfg_q;
      end else begin
         rd_d = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_o_q <= 1'b1;
         pin_oe_q <= 1'b1;
         pu_q <= 1'b1;
         hold_q <= 1'b1;
         rsel_q <= 1'b1;
         eflag_q <= 1'b0;
         cflag_q <= 1'b0;
         rd_q <= 8'h00;
      end else begin
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         pu_q <= pu_d;
         hold_q <= hold_d;
         rsel_q <= rsel_d;
         eflag_q <= eflag_d;
         cflag_q <= cflag_d;
         rd_q <= rd_d;
      end
   end

   assign reg_rd_data = rd_q;
   assign touch_interrupt_pin_o = pin_o_q;
   assign touch_interrupt_pin_oe = pin_oe_q;
   assign interrupt_pin_pullup_enable = pu_q;
   assign data_out_holder_enable = hold_q;
   assign touch_detect_resistor_select = rsel_q;
   assign edge_event_flag = eflag_q;
   assign continuous_touch_flag = cflag_q;

   // pulse length measurement for checking
   logic [23:0] len_q, exp_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         len_q <= 24'h000000;
         exp_q <= 24'h000000;
      end else begin
         len_q <= (state_q == ev_pulse) ? len_q + 24'h000001 : 24'h000000;
         if (state_q == ev_idle && state_d == ev_pulse) begin
            exp_q <= 24'(edge_ticks(cfg_q[`CFG_ETIME_HI:`CFG_ETIME_LO]) * OSC_DIV);
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence pulse_start_s;
      state_q == ev_idle && edge_style && touch_event;
   endsequence
   sequence pulse_end_s;
      state_q == ev_pulse ##1 state_q == ev_idle;
   endsequence

   edge_len_a: assert property (pulse_end_s |-> len_q == exp_q) // R1
      else $error("edge pulse length wrong");
   cont_pin_a: assert property (!auto_mode && !cfg_q[`CFG_EDGE_BIT] && !cfg_q[`CFG_MASK_BIT]
      && (touch_present || conv_busy) |=> (pin_oe_q && !pin_o_q)) // R2
      else $error("continuous interrupt not asserted");
   edge_start_a: assert property (pulse_start_s |=> state_q == ev_pulse ##1 (cfg_q[`CFG_MASK_BIT]
      || (pin_oe_q && !pin_o_q))) // R3
      else $error("edge pulse not started");
   mask_hold_a: assert property (cfg_q[`CFG_MASK_BIT] |=> (pin_o_q || !pin_oe_q)) // R4
      else $error("masked pin driven low");
   drive_type_a: assert property (!open_drain |=> pin_oe_q && !pu_q) // R5
      else $error("push-pull drive wrong");
   holder_en_a: assert property ($rose(cfg_q[`CFG_HOLD_BIT]) |=> hold_q) // R6
      else $error("bus holder not enabled");
   edge_flag_a: assert property ((auto_mode || !cfg_q[`CFG_EDGE_BIT]) |=> !eflag_q) // R7
      else $error("edge flag outside edge style");
   cont_flag_a: assert property (!auto_mode && !cfg_q[`CFG_EDGE_BIT] && !touch_present && !conv_busy
      |=> !cflag_q ##1 1'b1) // R8
      else $error("continuous flag set without touch");

endmodule

// ---- host_pin_model.sv ----
// Purpose: host side view of the touch interrupt pin
// Assumes: no board pullup on the pin
// Notes: a released pin without pullup toggles
`timescale 1ns/10ps
module host_pin_model (
   input wire logic clk_sys,
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic pull_en,
   output logic pin_level
);
   logic float_q = 1'b0;
   always @(posedge clk_sys) begin
      float_q <= ~float_q;
   end
   assign pin_level = pin_oe ? pin_o : (pull_en ? 1'b1 : float_q);
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench of the interrupt output block
// Assumes: OSC_DIV set to 2
// Notes: inputs change at falling edges
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 0, rstn = 0, reg_wr_en = 0, auto_mode = 0;
   logic touch_present = 0, conv_busy = 0, touch_event = 0;
   logic [6:0] reg_addr = 7'h01;
   logic [7:0] reg_wr_data = 8'h00, rd, d;
   logic pin_o, pin_oe, pu, hold, rsel, eflag, cflag, lvl;
   int fail_count = 0, n_tests = 0, len;
   logic [31:0] seed = 32'h5e9c9120;
   always #2 clk_sys = ~clk_sys;
   touch_irq_output_config #(.OSC_DIV(2)) DUT (.clk_sys(clk_sys), .rstn(rstn), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .auto_mode(auto_mode), .touch_present(touch_present),
      .conv_busy(conv_busy), .touch_event(touch_event), .reg_rd_data(rd), .touch_interrupt_pin_o(pin_o),
      .touch_interrupt_pin_oe(pin_oe), .interrupt_pin_pullup_enable(pu), .data_out_holder_enable(hold),
      .touch_detect_resistor_select(rsel), .edge_event_flag(eflag), .continuous_touch_flag(cflag));
   host_pin_model host (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pu), .pin_level(lvl));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] low_len(input logic [1:0] c);
      return (c == 2'h3) ? 16'd256 : 16'((4 << (2 * c)) * 2);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wr_data = v;
      reg_wr_en = 1;
      @(negedge clk_sys);
      reg_wr_en = 0;
      reg_addr = 7'h01;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      test_done;
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      rstn = 1;
      repeat (2) @(negedge clk_sys);
      check(16'(rd), 16'hf0);
      check(16'({rsel, hold, pu}), 16'h7);
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         wr(7'h01, d);
         wr(7'h05, ~d);
         check(16'(rd), 16'(d));
         check(16'(hold), 16'(d[6]));
         check(16'(pu), 16'(d[5] & d[4]));
         check(16'(rsel), 16'(d[7]));
      end
      $display("register test done");
      wr(7'h01, 8'h00);
      touch_present = 1;
      repeat (3) @(negedge clk_sys);
      check(16'({pin_o, pin_oe, cflag, eflag}), 16'h6);
      reg_addr = 7'h00;
      repeat (2) @(negedge clk_sys);
      check(16'(rd), 16'h01);
      reg_addr = 7'h01;
      touch_present = 0;
      conv_busy = 1;
      repeat (3) @(negedge clk_sys);
      check(16'(cflag), 16'h1);
      conv_busy = 0;
      repeat (3) @(negedge clk_sys);
      check(16'({pin_o, cflag}), 16'h2);
      touch_present = 1;
      wr(7'h01, 8'h0c);
      check(16'({pin_o, pin_oe}), 16'h3);
      wr(7'h01, 8'h38);
      check(16'({pin_oe, lvl}), 16'h1);
      wr(7'h01, 8'h10);
      check(16'({pin_o, pin_oe}), 16'h1);
      $display("continuous and mask test done");
      wr(7'h01, 8'h04);
      check(16'({eflag, cflag}), 16'h2);
      reg_addr = 7'h00;
      repeat (2) @(negedge clk_sys);
      check(16'(rd), 16'h02);
      reg_addr = 7'h01;
      auto_mode = 1;
      repeat (3) @(negedge clk_sys);
      check(16'({eflag, pin_o}), 16'h1);
      auto_mode = 0;
      touch_present = 0;
      for (int c = 0; c < 4; c++) begin
         wr(7'h01, 8'h04 | 8'(c));
         touch_event = 1;
         @(negedge clk_sys);
         touch_event = 0;
         len = 0;
         for (int k = 0; k < 300; k++) begin
            @(negedge clk_sys);
            touch_event = (k == 3);
            if (pin_o === 1'b0) len++;
         end
         check(16'(len), low_len(2'(c)));
      end
      $display("edge pulse test done");
      test_done;
   end
endmodule
